// ### core/headset_key_press_detector.sv
// headset key press detector: debounce, mic location and press/release flags
// assumes the line level is produced by an external converter on another clock
module headset_key_press_detector #(
  parameter int PRESS_CYCLES = key_detect_pkg::PRESS_DEBOUNCE_CYCLES,
  parameter int RELEASE_CYCLES = key_detect_pkg::RELEASE_DEBOUNCE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic key_detect_enable,
  input wire logic manual_route_override,
  input wire logic ring_bias_switch,
  input wire logic sleeve_bias_switch,
  input wire logic ring_ground_switch,
  input wire logic sleeve_ground_switch,
  input wire logic accessory_removed,
  input wire logic [2:0] microphone_bias_level,
  input wire logic [6:0] press_threshold,
  input wire logic [6:0] key_boundary_threshold1,
  input wire logic [6:0] key_boundary_threshold2,
  input wire logic [6:0] key_boundary_threshold3,
  input wire logic threshold_write,
  input wire logic [6:0] ring_level,
  input wire logic [6:0] sleeve_level,
  input wire logic flags_read,
  output logic [7:0] key_flags,
  output logic [6:0] boundary1,
  output logic [6:0] boundary2,
  output logic [6:0] boundary3,
  output logic key_interrupt
);
  // ****************************************
  // parameter checks
  // ****************************************
  // the debounce timer is 24 bits wide, so longer counts cannot be served
  if (PRESS_CYCLES < 1 || RELEASE_CYCLES < 1 || PRESS_CYCLES > 16777215 ||
      RELEASE_CYCLES > 16777215)
  begin
    $error("debounce counts out of range");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [6:0] ring_meta;
  logic [6:0] ring_sync;
  logic [6:0] sleeve_meta;
  logic [6:0] sleeve_sync;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ring_meta <= 7'h7F;
      ring_sync <= 7'h7F;
      sleeve_meta <= 7'h7F;
      sleeve_sync <= 7'h7F;
    end
    else
    begin
      ring_meta <= ring_level;
      ring_sync <= ring_meta;
      sleeve_meta <= sleeve_level;
      sleeve_sync <= sleeve_meta;
    end
  end

  // ****************************************
  // thresholds
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      boundary1 <= key_detect_pkg::THRESHOLD1_RESET;
      boundary2 <= key_detect_pkg::THRESHOLD2_RESET;
      boundary3 <= key_detect_pkg::THRESHOLD3_RESET;
    end
    else if (threshold_write)
    begin
      boundary1 <= key_boundary_threshold1;
      boundary2 <= key_boundary_threshold2;
      boundary3 <= key_boundary_threshold3;
    end
  end

  // level codes count six-ohm steps at the nominal bias; the bias setting
  // shifts the line code down so a higher bias reads the same resistance
  function automatic logic [6:0] scale_level(input logic [6:0] raw, input logic [2:0] bias);
    logic [7:0] adj;
    adj = {1'b0, raw};
    if (adj > {5'h00, bias})
      adj = adj - {5'h00, bias};
    else
      adj = 8'h00;
    return adj[6:0];
  endfunction

  // ****************************************
  // mic location
  // ****************************************
  key_detect_pkg::mic_location_t mic_location;
  always_comb
  begin
    if (!manual_route_override)
      mic_location = sleeve_bias_switch ? key_detect_pkg::mic_sleeve_t_v
                                        : key_detect_pkg::mic_ring_t_v;
    else if (ring_bias_switch && !sleeve_bias_switch && !ring_ground_switch &&
             sleeve_ground_switch)
      mic_location = key_detect_pkg::mic_ring_t_v;
    else if (!ring_bias_switch && sleeve_bias_switch && ring_ground_switch &&
             !sleeve_ground_switch)
      mic_location = key_detect_pkg::mic_sleeve_t_v;
    else
      mic_location = key_detect_pkg::mic_none_t_v;
  end

  logic [6:0] line_level;
  always_comb
  begin
    line_level = (mic_location == key_detect_pkg::mic_ring_t_v) ? ring_sync : sleeve_sync;
    line_level = scale_level(line_level, microphone_bias_level);
  end

  logic line_low;
  assign line_low = (line_level < press_threshold);

  logic [1:0] key_now;
  level_classifier #(.WIDTH(7)) classify (
    .level(line_level),
    .threshold1(boundary1),
    .threshold2(boundary2),
    .threshold3(boundary3),
    .key_index(key_now)
  );

  // ****************************************
  // debounce state machine
  // ****************************************
  logic active;
  assign active = key_detect_enable && !accessory_removed &&
                  (mic_location != key_detect_pkg::mic_none_t_v);

  key_detect_pkg::detect_state_t state;
  logic [23:0] timer;
  logic [1:0] held_key;
  logic press_event;
  logic release_event;
  assign press_event = (state == key_detect_pkg::st_press_wait) && line_low &&
                       (timer >= 24'(PRESS_CYCLES));
  assign release_event = (state == key_detect_pkg::st_release_wait) && !line_low &&
                         (timer >= 24'(RELEASE_CYCLES));

  always_ff @(posedge clock)
  begin
    if (reset || !active)
    begin
      state <= key_detect_pkg::st_idle;
      timer <= 24'h000000;
      held_key <= 2'h0;
    end
    else
    begin
      unique case (state)
        key_detect_pkg::st_idle:
        begin
          timer <= 24'h000001;
          if (line_low)
            state <= key_detect_pkg::st_press_wait;
        end
        key_detect_pkg::st_press_wait:
        begin
          timer <= timer + 24'h000001;
          if (!line_low)
            state <= key_detect_pkg::st_idle;
          else if (press_event)
          begin
            state <= key_detect_pkg::st_held;
            held_key <= key_now;
          end
        end
        key_detect_pkg::st_held:
        begin
          timer <= 24'h000001;
          if (!line_low)
            state <= key_detect_pkg::st_release_wait;
        end
        key_detect_pkg::st_release_wait:
        begin
          timer <= timer + 24'h000001;
          if (line_low)
            state <= key_detect_pkg::st_held;
          else if (release_event)
            state <= key_detect_pkg::st_idle;
        end
      endcase
    end
  end

  // ****************************************
  // flags and interrupt
  // ****************************************
  // bits 3:0 press flags, bits 7:4 release flags
  logic [7:0] next_flags;
  always_comb
  begin
    next_flags = flags_read ? 8'h00 : key_flags;
    // events win over a read in the same cycle so nothing is lost
    if (press_event)
    begin
      next_flags[key_now] = 1'b1;
      next_flags[4 + key_now] = 1'b0;
    end
    if (release_event)
      next_flags[4 + held_key] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (reset || !key_detect_enable || accessory_removed)
      key_flags <= key_detect_pkg::FLAGS_RESET;
    else
      key_flags <= next_flags;
  end

  always_ff @(posedge clock)
  begin
    if (reset || !key_detect_enable || accessory_removed)
      key_interrupt <= 1'b0;
    else
      key_interrupt <= (next_flags != 8'h00);
  end
endmodule

// ### core/key_detect_pkg.sv
// shared constants for the headset key press detector
// assumes a 20 MHz system clock and a sampled microphone-line level code
package key_detect_pkg;
  localparam int CLOCK_HZ = 20000000;
  localparam int LEVEL_WIDTH = 7;
  localparam int KEY_COUNT = 4;
  localparam int OHMS_PER_STEP = 6;
  localparam logic [6:0] THRESHOLD1_RESET = 7'h10;
  localparam logic [6:0] THRESHOLD2_RESET = 7'h18;
  localparam logic [6:0] THRESHOLD3_RESET = 7'h28;
  localparam int PRESS_DEBOUNCE_US = 1000;
  localparam int RELEASE_DEBOUNCE_US = 1000;
  localparam int PRESS_DEBOUNCE_CYCLES = (PRESS_DEBOUNCE_US * (CLOCK_HZ / 1000000));
  localparam int RELEASE_DEBOUNCE_CYCLES = (RELEASE_DEBOUNCE_US * (CLOCK_HZ / 1000000));
  localparam int BIAS_LEVEL_WIDTH = 3;
  localparam logic [2:0] BIAS_LEVEL_RESET = 3'h0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  typedef enum logic [1:0] {mic_none_t_v, mic_ring_t_v, mic_sleeve_t_v} mic_location_t;
  typedef enum logic [1:0] {st_idle, st_press_wait, st_held, st_release_wait} detect_state_t;
endpackage

// ### core/level_classifier.sv
// classifies a microphone-line level into a key number
// assumes the level code and thresholds are in the same scaled units
module level_classifier #(
  parameter int WIDTH = 7
) (
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] threshold1,
  input wire logic [WIDTH-1:0] threshold2,
  input wire logic [WIDTH-1:0] threshold3,
  output logic [1:0] key_index
);
  // boundaries are only meaningful when strictly ascending
  always_comb
  begin
    if (level < threshold1)
      key_index = 2'h0;
    else if (level < threshold2)
      key_index = 2'h1;
    else if (level < threshold3)
      key_index = 2'h2;
    else
      key_index = 2'h3;
  end
endmodule

// ### verification/key_detect_asserts.sv
// port checker for the headset key press detector
// assumes a synchronous active-high reset and registered flag outputs
module key_detect_asserts #(
  parameter int PRESS_CYCLES = key_detect_pkg::PRESS_DEBOUNCE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic key_detect_enable,
  input wire logic accessory_removed,
  input wire logic flags_read,
  input wire logic threshold_write,
  input wire logic [6:0] key_boundary_threshold1,
  input wire logic [7:0] key_flags,
  input wire logic [6:0] boundary1,
  input wire logic key_interrupt
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // consecutive enabled cycles; a flag cannot appear before a full debounce
  int on_cycles;
  always_ff @(posedge clock)
  begin
    if (reset || !key_detect_enable || accessory_removed)
      on_cycles <= 0;
    else if (on_cycles < PRESS_CYCLES)
      on_cycles <= on_cycles + 1;
  end
  sequence new_press;
    |(key_flags[3:0] & ~$past(key_flags[3:0]));
  endsequence
  a_off_clears: assert property (
    !key_detect_enable |=> key_flags == 8'h00 && !key_interrupt) else $error("flags survive disable");
  a_removal_clears: assert property (
    accessory_removed |=> key_flags == 8'h00) else $error("flags survive removal");
  a_int_while_flags: assert property (
    key_flags != 8'h00 |-> key_interrupt) else $error("interrupt low with flags set");
  a_int_drop_empty: assert property (
    $fell(key_interrupt) |-> key_flags == 8'h00) else $error("interrupt fell with flags set");
  a_press_clears_release: assert property (
    new_press |-> (key_flags[3:0] & ~$past(key_flags[3:0]) & key_flags[7:4]) == 4'h0)
    else $error("release flag kept on press");
  a_flags_accumulate: assert property (
    |($past(key_flags[3:0]) & ~key_flags[3:0]) |-> $past(flags_read) || $past(reset)
      || !$past(key_detect_enable) || $past(accessory_removed)) else $error("press flag lost");
  a_read_clears: assert property (
    flags_read |=> (key_flags & $past(key_flags)) == 8'h00) else $error("read left flags");
  a_boundary_load: assert property (
    threshold_write |=> boundary1 == $past(key_boundary_threshold1)) else $error("no load");
  a_boundary_reset: assert property (
    $fell(reset) |-> boundary1 == 7'h10) else $error("boundary reset value");
  a_debounce_time: assert property (
    |(key_flags & ~$past(key_flags)) |-> on_cycles >= PRESS_CYCLES) else $error("flag too early");
endmodule
bind headset_key_press_detector key_detect_asserts #(.PRESS_CYCLES(PRESS_CYCLES)) i_chk (
  .clock, .reset, .key_detect_enable, .accessory_removed, .flags_read, .threshold_write,
  .key_boundary_threshold1, .key_flags, .boundary1, .key_interrupt);

// ### verification/headset_line_model.sv
// headset microphone line: key network seen through the jack contacts
// assumes bias is present; the contact not carrying the mic is grounded
module headset_line_model (
  input wire logic [2:0] key,
  input wire logic mic_on_ring,
  output logic [6:0] ring_level,
  output logic [6:0] sleeve_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] mic;
  always_comb
  begin
    case (key) // codes sit mid-bin, well clear of ascending boundaries
      3'h1: mic = 7'h08;
      3'h2: mic = 7'h14;
      3'h3: mic = 7'h20;
      3'h4: mic = 7'h30;
      default: mic = 7'h7F; // bias pulls the idle line to the top code
    endcase
    // grounded contact reads zero, so monitoring the wrong one looks like a press
    ring_level = mic_on_ring ? mic : 7'h00;
    sleeve_level = mic_on_ring ? 7'h00 : mic;
  end
endmodule

// ### verification/headset_key_press_detector_test.sv
// self-checking bench for the headset key press detector
// assumes the line model and debounce counts shortened to 8 cycles
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module headset_key_press_detector_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset, key_detect_enable, manual_route_override, accessory_removed;
  logic flags_read, threshold_write, key_interrupt;
  logic [3:0] sw;
  logic [2:0] microphone_bias_level, key;
  logic [6:0] threshold1, press_level, ring_level, sleeve_level, boundary1, boundary2, boundary3;
  logic [7:0] key_flags;
  int failures, checks, cycles;
  headset_line_model i_headset_line_model (.key(key), .mic_on_ring(sw[3]),
    .ring_level(ring_level), .sleeve_level(sleeve_level));
  headset_key_press_detector #(.PRESS_CYCLES(8), .RELEASE_CYCLES(8))
    i_headset_key_press_detector (.clock(clock), .reset(reset),
    .key_detect_enable(key_detect_enable), .manual_route_override(manual_route_override),
    .ring_bias_switch(sw[3]), .sleeve_bias_switch(sw[2]), .ring_ground_switch(sw[1]),
    .sleeve_ground_switch(sw[0]), .accessory_removed(accessory_removed),
    .microphone_bias_level(microphone_bias_level), .press_threshold(press_level),
    .key_boundary_threshold1(threshold1), .key_boundary_threshold2(7'h18),
    .key_boundary_threshold3(7'h28), .threshold_write(threshold_write),
    .ring_level(ring_level), .sleeve_level(sleeve_level), .flags_read(flags_read),
    .key_flags(key_flags), .boundary1(boundary1), .boundary2(boundary2),
    .boundary3(boundary3), .key_interrupt(key_interrupt));
  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      report_and_stop();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task stroke(input logic [2:0] k, input logic [7:0] ep, input logic [7:0] er);
    key = k;
    tick(30);
    `CHECK(key_flags, ep)
    `CHECK(key_interrupt, |ep)
    key = 3'h0;
    tick(30);
    `CHECK(key_flags, er)
  endtask
  task clear();
    flags_read = 1'h1;
    tick(1);
    flags_read = 1'h0;
    tick(1);
    `CHECK({key_interrupt, key_flags}, 9'h000)
  endtask
  initial
  begin
    {reset, key_detect_enable, manual_route_override, accessory_removed} = 4'h8;
    {flags_read, threshold_write, sw, microphone_bias_level, key} = 12'h000;
    threshold1 = 7'h10;
    press_level = 7'h40;
    tick(6);
    reset = 1'h0;
    `CHECK({boundary1, boundary2, boundary3}, {7'h10, 7'h18, 7'h28})
    stroke(3'h1, 8'h00, 8'h00);
    key_detect_enable = 1'h1;
    // both mic contacts, with and without the manual override
    for (int k = 1; k <= 4; k++)
    begin
      manual_route_override = k[1];
      sw = k[0] ? 4'h6 : 4'h9;
      tick(4);
      stroke(k[2:0], 8'h01 << (k - 1), 8'h11 << (k - 1));
      clear();
    end
    repeat (2)
    begin
      key = 3'h1;
      tick(5);
      key = 3'h0;
      tick(2);
    end
    tick(30);
    `CHECK(key_flags, 8'h00)
    // leave only a release flag standing so the next press must clear it
    key = 3'h1;
    tick(30);
    clear();
    key = 3'h0;
    tick(30);
    `CHECK(key_flags, 8'h10)
    stroke(3'h1, 8'h01, 8'h11);
    stroke(3'h2, 8'h13, 8'h33);
    key = 3'h1;
    tick(30);
    `CHECK(key_flags, 8'h23)
    tick(40);
    `CHECK(key_flags, 8'h23)
    key_detect_enable = 1'h0;
    tick(2);
    `CHECK({key_interrupt, key_flags}, 9'h000)
    key = 3'h0;
    key_detect_enable = 1'h1;
    tick(30);
    stroke(3'h3, 8'h04, 8'h44);
    accessory_removed = 1'h1;
    tick(1);
    accessory_removed = 1'h0;
    `CHECK(key_flags, 8'h00)
    manual_route_override = 1'h1;
    sw = 4'h0;
    stroke(3'h1, 8'h00, 8'h00);
    sw = 4'h6;
    microphone_bias_level = 3'h7;
    tick(4);
    stroke(3'h2, 8'h01, 8'h11);
    clear();
    microphone_bias_level = 3'h0;
    threshold1 = 7'h15;
    threshold_write = 1'h1;
    tick(1);
    threshold_write = 1'h0;
    `CHECK(boundary1, 7'h15)
    stroke(3'h2, 8'h01, 8'h11);
    clear();
    // key 4 sits exactly at the lowered press level, so it never counts as low
    press_level = 7'h30;
    stroke(3'h4, 8'h00, 8'h00);
    report_and_stop();
  end
endmodule
